/* ramp_position_threshold_regs.v */
// APB register bank: high-speed threshold, position, velocity, acceleration
// Assumes ramp generator and step timer on sys_clk; APB on sys_clk
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "ramp_position_threshold_regs.vh"
module ramp_position_threshold_regs (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [9:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Ramp generator and step timer
  input  wire [19:0] measured_step_period,
  input  wire        electrical_period_tick,
  input  wire [31:0] target_position,
  input  wire        ramp_allows_motion,
  input  wire [23:0] ramp_velocity,
  input  wire [23:0] ramp_accel,
  input  wire        ramp_position_step,
  input  wire        ramp_position_dir_neg,
  // Chopper and driver controls
  output reg         current_reduction_disable,
  output reg         voltage_pwm_disable,
  output reg         chopper_mode_select,
  output reg         fast_decay_zero,
  output reg         full_step_mode,
  output reg         stall_detect_blank,
  output reg         motion_start,
  output reg  [31:0] position_out
);
  // Software visible state
  reg  [`THRESHOLD_W-1:0] threshold_q;
  reg  [31:0]             position_q;
  reg  [`CTRL_W-1:0]      ctrl_q;

  // Copies of ramp generator state
  reg  [`VELOCITY_W-1:0]  velocity_q;
  reg  [`ACCEL_W-1:0]     accel_q;

  // Speed band and motion start tracking
  reg                     high_speed_q;
  reg                     start_pending_q;
  wire                    high_speed_d;
  wire                    crossing;
  wire                    blank_q;

  // Bus decode
  wire [7:0]              idx;
  wire                    wr_en;
  wire                    rd_en;
  wire                    pos_wr;

  // Read path
  reg  [31:0]             rd_d;
  reg                     err_d;

  // Address decode; low address bits ignored, one word per register
  // Write strobe only in the first access cycle, so a held access
  // phase never stores twice
  assign idx   = paddr[9:2];
  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  assign pos_wr = wr_en && (idx == `IDX_POSITION);

  // threshold compare
  // Equal period counts as high speed
  assign high_speed_d = (measured_step_period <= threshold_q);
  // either direction crossing
  // Compared with the registered band, so each change gives one pulse
  assign crossing = (high_speed_d != high_speed_q);

  // Threshold and control registers
  always @(posedge sys_clk) begin
    if (!nrst) begin
      threshold_q <= `THRESHOLD_RST;
      ctrl_q      <= `CTRL_RST;
    end else if (wr_en) begin
      if (idx == `IDX_THRESHOLD)
        threshold_q <= pwdata[`THRESHOLD_W-1:0];
      if (idx == `IDX_MOTION_CTRL)
        ctrl_q <= pwdata[`CTRL_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      position_q <= `POSITION_RST;
    end else if (pos_wr) begin
      position_q <= pwdata;
    end else if (ramp_position_step) begin
      position_q <= ramp_position_dir_neg ? position_q - 32'h1 : position_q + 32'h1;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      velocity_q <= `VELOCITY_RST;
      accel_q    <= `ACCEL_RST;
    end else begin
      velocity_q <= ramp_velocity;
      accel_q    <= ramp_accel;
    end
  end

  // start on position write
  // Compare uses the freshly stored position, one cycle after the write
  // Start is a single pulse; a held level would restart every cycle
  always @(posedge sys_clk) begin
    if (!nrst) begin
      start_pending_q <= 1'b0;
      motion_start    <= 1'b0;
    end else begin
      start_pending_q <= pos_wr && ctrl_q[`CTRL_POS_MODE_BIT];
      motion_start    <= start_pending_q && (position_q != target_position)
                         && ramp_allows_motion;
    end
  end

  // Speed state and driver controls
  always @(posedge sys_clk) begin
    if (!nrst) begin
      high_speed_q              <= 1'b0;
      current_reduction_disable <= 1'b0;
      voltage_pwm_disable       <= 1'b0;
      chopper_mode_select       <= 1'b0;
      fast_decay_zero           <= 1'b0;
      full_step_mode            <= 1'b0;
      stall_detect_blank        <= 1'b0;
      position_out              <= `POSITION_RST;
    end else begin
      high_speed_q              <= high_speed_d;
      current_reduction_disable <= high_speed_d;
      voltage_pwm_disable       <= high_speed_d;
      chopper_mode_select       <= high_speed_d && ctrl_q[`CTRL_HS_CHOP_BIT];
      fast_decay_zero           <= high_speed_d && ctrl_q[`CTRL_HS_CHOP_BIT];
      full_step_mode            <= high_speed_d && ctrl_q[`CTRL_HS_FULLSTEP_BIT];
      stall_detect_blank        <= blank_q || crossing;
      position_out              <= position_q;
    end
  end

  // Blanking timer
  stall_blank_timer u_blank (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .crossing    (crossing),
    .period_tick (electrical_period_tick),
    .blank_q     (blank_q)
  );

  // Read mux and decode
  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (idx)
      `IDX_THRESHOLD:     rd_d = {`THRESHOLD_PAD, threshold_q};
      `IDX_POSITION:      rd_d = position_q;
      `IDX_VELOCITY:      rd_d = {{`VELOCITY_EXT_W{velocity_q[`VELOCITY_W-1]}}, velocity_q};
      `IDX_ACCEL:         rd_d = {`ACCEL_PAD, accel_q};
      `IDX_MOTION_CTRL:   rd_d = {`CTRL_PAD, ctrl_q};
      `IDX_MOTION_STATUS: begin
        rd_d[`STAT_HIGH_SPEED_BIT]  = high_speed_q;
        rd_d[`STAT_STALL_BLANK_BIT] = stall_detect_blank;
        rd_d[`STAT_START_BIT]       = motion_start;
      end
      default:            err_d = 1'b1;
    endcase
  end

  // APB answer, one wait state
  // Ready pulses for one cycle; read data stays until the next read
  // Unmapped index answers with error and zero data, writes dropped
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && err_d;
      if (rd_en)
        prdata <= err_d ? 32'h00000000 : rd_d;
    end
  end
endmodule

/* ramp_position_threshold_regs.vh */
// Register map and constants for the per-motor threshold/position bank
// Included by the design files; holds definitions only
`ifndef RAMP_POSITION_THRESHOLD_REGS_VH
`define RAMP_POSITION_THRESHOLD_REGS_VH
// Printed offsets are register indices; byte address is index times four
`define IDX_THRESHOLD       8'h17
`define IDX_POSITION        8'h18
`define IDX_VELOCITY        8'h19
`define IDX_ACCEL           8'h1A
`define IDX_MOTION_CTRL     8'h30
`define IDX_MOTION_STATUS   8'h31
`define THRESHOLD_W         20
`define VELOCITY_W          24
`define ACCEL_W             24
`define THRESHOLD_RST       20'h00000
`define POSITION_RST        32'h00000000
`define VELOCITY_RST        24'h000000
`define ACCEL_RST           24'h000000
// Motion control register fields
`define CTRL_HS_CHOP_BIT    0
`define CTRL_HS_FULLSTEP_BIT 1
`define CTRL_POS_MODE_BIT   2
`define CTRL_W              3
`define CTRL_RST            3'h0
// Motion status register fields
`define STAT_HIGH_SPEED_BIT 0
`define STAT_STALL_BLANK_BIT 1
`define STAT_START_BIT      2
// Stall blanking length in electrical periods (two to three)
`define BLANK_PERIODS       2'h3
`define BLANK_CNT_W         2
`define BLANK_CNT_ZERO      2'h0
`define BLANK_CNT_LAST      2'h1
// Zero padding above narrow fields on reads; velocity is sign extended by VELOCITY_EXT_W bits
`define THRESHOLD_PAD       12'h000
`define ACCEL_PAD           8'h00
`define CTRL_PAD            29'h00000000
`define VELOCITY_EXT_W      8
`endif

/* ramp_position_threshold_regs_monitor.sv */
// Checker for the threshold/position register bank
// Assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps
module ramp_position_threshold_regs_monitor (
  // Clock, reset and bus
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] prdata,
  // Driver controls
  input wire logic        current_reduction_disable,
  input wire logic        voltage_pwm_disable,
  input wire logic        motion_start,
  input wire logic        chopper_mode_select,
  input wire logic        fast_decay_zero,
  input wire logic        full_step_mode,
  input wire logic        stall_detect_blank
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no ready after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_modes; voltage_pwm_disable == current_reduction_disable; endproperty
  a_modes: assert property (p_modes) else $error("speed modes differ");
  property p_chop; chopper_mode_select |-> fast_decay_zero && current_reduction_disable;
  endproperty
  a_chop: assert property (p_chop) else $error("chopper switch wrong");
  property p_full; full_step_mode |-> current_reduction_disable; endproperty
  a_full: assert property (p_full) else $error("full step at low speed");
  property p_start;
    motion_start |-> $past(psel && penable && pwrite && !pready && paddr[9:2] == 8'h18, 2);
  endproperty
  a_start: assert property (p_start) else $error("start without write");
  property p_blank; $changed(current_reduction_disable) |-> ##[0:2] stall_detect_blank;
  endproperty
  a_blank: assert property (p_blank) else $error("no blanking on crossing");
endmodule

/* stall_blank_timer.v */
// Stall detection blanking timer after a threshold crossing
// Assumes a one-cycle electrical period pulse from the commutation logic
`timescale 1ns/1ps
`include "ramp_position_threshold_regs.vh"
module stall_blank_timer (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       nrst,
  // Events
  input  wire       crossing,
  input  wire       period_tick,
  // Result
  output reg        blank_q
);
  reg [`BLANK_CNT_W-1:0] cnt_q;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q   <= `BLANK_CNT_ZERO;
      blank_q <= 1'b0;
    end else if (crossing) begin
      // New crossing restarts the full blanking span
      cnt_q   <= `BLANK_PERIODS;
      blank_q <= 1'b1;
    end else if (period_tick && cnt_q != `BLANK_CNT_ZERO) begin
      cnt_q   <= cnt_q - `BLANK_CNT_LAST;
      blank_q <= (cnt_q != `BLANK_CNT_LAST);
    end
  end
endmodule

/* tb.sv */
// Self-checking bench for the threshold/position register bank
// Assumes the bank alone, driven over its APB and ramp ports
`timescale 1ns/1ps
module tb;
  logic        sys_clk, nrst, psel, penable, pwrite, tick, allow, step, dneg, e;
  logic [9:0]  paddr;
  logic [31:0] pwdata, target, rdv;
  logic [19:0] period;
  logic [23:0] vel, acc;
  wire  [31:0] prdata, pos_out;
  wire         pready, pslverr, crd, vpd, cms, fdz, fsm, blank, mstart;
  int          error_cnt, check_count, starts;
  ramp_position_threshold_regs u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measured_step_period(period),
    .electrical_period_tick(tick), .target_position(target), .ramp_allows_motion(allow),
    .ramp_velocity(vel), .ramp_accel(acc), .ramp_position_step(step),
    .ramp_position_dir_neg(dneg), .current_reduction_disable(crd),
    .voltage_pwm_disable(vpd), .chopper_mode_select(cms), .fast_decay_zero(fdz),
    .full_step_mode(fsm), .stall_detect_blank(blank), .motion_start(mstart),
    .position_out(pos_out));
  // Clock and start pulse counter
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (mstart === 1'b1) starts <= starts + 1;
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer, held until ready
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1;
    // Wait for the answer; only the watchdog ends a hung wait
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge sys_clk);
  endtask
  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(0, idx, 32'h0);
    chk($sformatf("reg %h", idx), exp, rdv);
  endtask
  task ticks(input int n);
    repeat (n) begin
      tick <= 1; @(posedge sys_clk); tick <= 0; @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task t_reset;
    for (int i = 8'h17; i <= 8'h1A; i++) rdchk(i[7:0], 32'h0);
    rdchk(8'h30, 32'h0);
    $display("t_reset done");
  endtask
  task t_regs;
    apb(1, 8'h17, 32'hFFFFFFFF);
    rdchk(8'h17, 32'h000FFFFF);
    apb(1, 8'h18, 32'h80000001);
    rdchk(8'h18, 32'h80000001);
    dneg <= 1; step <= 1; @(posedge sys_clk); step <= 0;
    rdchk(8'h18, 32'h80000000);
    vel <= 24'h800001; acc <= 24'hABCDEF;
    apb(1, 8'h19, 32'h0); apb(1, 8'h1A, 32'h0);
    rdchk(8'h19, 32'hFF800001);
    rdchk(8'h1A, 32'h00ABCDEF);
    rdchk(8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    $display("t_regs done");
  endtask
  task t_speed;
    apb(1, 8'h30, 32'h3); apb(1, 8'h17, 32'h64);
    period <= 20'h65; ticks(3);
    chk("modes slow", 32'h0, {crd, vpd, cms, fdz, fsm});
    period <= 20'h64; repeat (3) @(posedge sys_clk);
    chk("modes fast", 32'h1F, {crd, vpd, cms, fdz, fsm});
    ticks(2);
    chk("blank held", 32'h1, {31'h0, blank});
    ticks(1);
    chk("blank end", 32'h0, {31'h0, blank});
    apb(1, 8'h30, 32'h0);
    chk("modes gated", 32'h18, {crd, vpd, cms, fdz, fsm});
    rdchk(8'h31, 32'h1);
    $display("t_speed done");
  endtask
  task t_move;
    target <= 32'h5; allow <= 1;
    apb(1, 8'h30, 32'h4); apb(1, 8'h18, 32'h7); repeat (4) @(posedge sys_clk);
    chk("start differ", 32'h1, starts);
    apb(1, 8'h18, 32'h5); repeat (4) @(posedge sys_clk);
    chk("start equal", 32'h1, starts);
    // Homing style position change with motion blocked
    allow <= 0; apb(1, 8'h18, 32'h9); repeat (4) @(posedge sys_clk);
    chk("start held", 32'h1, starts);
    chk("position out", 32'h9, pos_out);
    $display("t_move done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, tick, allow, step, dneg} = 8'h00;
    paddr = 0; pwdata = 0; target = 0; period = 20'h10; vel = 0; acc = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    t_reset; t_regs; t_speed; t_move;
    finish_test;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    finish_test;
  end
endmodule
bind ramp_position_threshold_regs ramp_position_threshold_regs_monitor u_mon (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
  .current_reduction_disable(current_reduction_disable), .motion_start(motion_start),
  .voltage_pwm_disable(voltage_pwm_disable), .chopper_mode_select(chopper_mode_select),
  .fast_decay_zero(fast_decay_zero), .full_step_mode(full_step_mode),
  .stall_detect_blank(stall_detect_blank));
